// >>> rtl/isabg_pkg.sv
// Package for the ISA bus buffer glue block: strap codes, decode values,
// index register numbers and the carrier structs.
// Assumes a single 25 MHz clock domain and active-low asynchronous reset.
package isabg_pkg;

    // ****************************************
    // Widths and decode constants
    // ****************************************
    localparam int          ADDR_LO     = 2;
    localparam int          ADDR_HI     = 15;
    localparam int          ADDR_W      = ADDR_HI - ADDR_LO + 1;
    localparam int          BYTE_W      = 8;
    localparam logic [15:0] CLK_IDX_IO  = 16'h0070;
    localparam logic [15:0] CLK_DAT_IO  = 16'h0071;
    localparam logic [7:0]  IDX_CS_LO   = 8'hf8;
    localparam logic [7:0]  IDX_CS_HI   = 8'hf9;
    localparam logic [7:0]  IDX_PWR     = 8'hfa;
    localparam logic [ADDR_W-1:0] RFSH_RST = 14'h0000;
    localparam logic [7:0]  CS_LO_RST   = 8'h00;
    localparam logic [7:0]  CS_HI_RST   = 8'h00;
    localparam logic [2:0]  PWR_RST     = 3'h7;
    localparam int          STRAP_B7    = 7;
    localparam int          STRAP_B6    = 6;
    localparam int          STRAP_B4    = 4;
    localparam int          FIFO_DEPTH  = 8;

    // Pin 18/19/25 function sets selected by straps
    typedef enum logic [2:0] {
        ISABG_PM_EXTCLK = 3'b001,
        ISABG_PM_IOBUF  = 3'b010,
        ISABG_PM_PWR    = 3'b100
    } isabg_pinmode_t;

    // Command strobes, all active low
    typedef struct packed {
        logic ior_n;
        logic iow_n;
        logic memr_n;
        logic memw_n;
    } isabg_cmd_t;

    // Byte-lane controls from the chipset, all active low
    typedef struct packed {
        logic cpu_byte_to_sys_oe_n;
        logic sys_to_cpu_latch_oe_n;
        logic sys_to_cpu_latch_n;
    } isabg_lane_t;

endpackage : isabg_pkg

// >>> rtl/isabg_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ns
module isabg_fifo
    import isabg_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,      // Clock
    input  wire logic             i_arst_n,   // Async reset
    input  wire logic [WIDTH-1:0] i_data,     // Write data
    input  wire logic             i_valid,    // Write valid
    output logic                  o_ready,    // Not full
    output logic [WIDTH-1:0]      o_data,     // Read data
    output logic                  o_valid,    // Not empty
    input  wire logic             i_ready     // Reader takes word
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("isabg_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign o_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign o_valid = wr_q != rd_q;
    assign o_data  = mem[rd_q[AW-1:0]];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // isabg_fifo

// >>> rtl/isabg_top.sv
// ISA bus buffer glue: data/address buffers, command direction, refresh
// counter, strap-selected pins, clock chip decode, power port, resets.
// Assumes chipset strobes are synchronous to i_clk except the pins
// marked as synchronised.
`timescale 1ns/1ns
module isabg_top
    import isabg_pkg::*;
#(
    parameter int FDEPTH = FIFO_DEPTH
) (
    input  wire logic              i_clk,            // 25 MHz clock
    input  wire logic              i_arst_n,         // Power-good reset
    input  wire logic              i_system_reset_in_n, // Chipset reset
    input  wire logic              i_master_n,       // ISA master cycle
    input  wire logic              i_hold_ack_in,    // Hold acknowledge
    input  wire logic              i_rfsh_n,         // Refresh cycle
    input  wire logic              i_bidir_cmd,      // Two-way cmd config
    input  wire isabg_cmd_t        i_cmd,            // Chipset commands
    input  wire isabg_cmd_t        i_isa_cmd,        // ISA cmd pins in
    output isabg_cmd_t             o_isa_cmd,        // ISA cmd pins out
    output logic [3:0]             o_isa_cmd_oe,     // Cmd pin enables
    output logic                   o_low_meg_rd_n,   // Low-meg read
    output logic                   o_low_meg_wr_n,   // Low-meg write
    input  wire logic [ADDR_W-1:0] i_cpu_addr_bus,   // CPU address in
    output logic [ADDR_W-1:0]      o_cpu_addr_bus,   // CPU address out
    output logic                   o_cpu_addr_oe,    // CPU addr enable
    input  wire logic [ADDR_W-1:0] i_sa,             // ISA address in
    output logic [ADDR_W-1:0]      o_sa,             // ISA address out
    output logic                   o_sa_oe,          // ISA addr enable
    input  wire logic [1:0]        i_cpu_addr_low,   // CPU address 1:0
    input  wire logic              i_periph_bus_dir_n, // Low: SD to XD
    input  wire logic [7:0]        i_periph_data_bus, // XD in
    output logic [7:0]             o_periph_data_bus, // XD out
    output logic                   o_periph_data_oe, // XD enable
    input  wire logic [7:0]        i_sd,             // SD in
    output logic [7:0]             o_sd,             // SD out
    output logic                   o_sd_oe,          // SD enable
    input  wire logic [7:0]        i_cpu_data_bus,   // CPU byte 2 in
    output logic [7:0]             o_cpu_data_bus,   // CPU byte 2 out
    output logic                   o_cpu_data_oe,    // CPU byte enable
    input  wire isabg_lane_t       i_lane,           // Lane controls
    output logic                   o_ref,            // Refresh, high
    output logic                   o_aen,            // Address enable
    output logic                   o_pin18_out,      // Pin 18 out
    output logic                   o_pin18_oe,       // Pin 18 enable
    output logic                   o_pin19_out,      // Pin 19 out
    output logic                   o_pin19_oe,       // Pin 19 enable
    output logic                   o_pin25_out,      // Pin 25 out
    output logic                   o_ext_clock_addr_strobe, // Pin 26
    output logic                   o_power_port_bit0_n, // Power bit 0
    input  wire logic              i_power_port_latch_n, // Latch strobe
    input  wire logic              i_kbd_ctrl_clock_in, // Kbd ctrl clock
    output logic                   o_kbd_clock_out,  // Keyboard clock
    output logic                   o_kbd_clock_oe,   // Keyboard enable
    output logic                   o_isa_reset,      // ISA reset
    output logic                   o_local_bus_reset_n, // Local reset
    output logic                   o_fifo_full       // Peripheral FIFO
);

    initial begin
        if (FDEPTH < 2)
            $error("isabg_top: FDEPTH too small");
    end

    // ****************************************
    // Pin synchronisers: 3 stages, change once 2nd and 3rd agree
    // ****************************************
    logic [2:0] s_rfsh_q;
    logic [2:0] s_rst_q;
    logic [2:0] s_kbd_q;
    logic [2:0] s_ppl_q;
    logic       rfsh_n_q;
    logic       system_reset_in_n_n_q;
    logic       kbd_q;
    logic       ppl_n_q;
    logic       ppl_prev_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_rfsh_q <= 3'h7;
            s_rst_q  <= 3'h0;
            s_kbd_q  <= 3'h7;
            s_ppl_q  <= 3'h7;
        end else begin
            s_rfsh_q <= {s_rfsh_q[1:0], i_rfsh_n};
            s_rst_q  <= {s_rst_q[1:0], i_system_reset_in_n};
            s_kbd_q  <= {s_kbd_q[1:0], i_kbd_ctrl_clock_in};
            s_ppl_q  <= {s_ppl_q[1:0], i_power_port_latch_n};
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rfsh_n_q   <= 1'b1;
            system_reset_in_n_n_q <= 1'b0;
            kbd_q      <= 1'b1;
            ppl_n_q    <= 1'b1;
            ppl_prev_q <= 1'b1;
        end else begin
            if (s_rfsh_q[1] == s_rfsh_q[2]) rfsh_n_q <= s_rfsh_q[2];
            if (s_rst_q[1] == s_rst_q[2]) system_reset_in_n_n_q <= s_rst_q[2];
            if (s_kbd_q[1] == s_kbd_q[2]) kbd_q <= s_kbd_q[2];
            if (s_ppl_q[1] == s_ppl_q[2]) ppl_n_q <= s_ppl_q[2];
            ppl_prev_q <= ppl_n_q;
        end
    end

    // ****************************************
    // Straps and pin mode
    // ****************************************
    logic           strap_done_q;
    logic [2:0]     strap_q;
    isabg_pinmode_t pmode;

    // Caught once after reset release; pull-ups make unknown read high
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            strap_done_q <= 1'b0;
            strap_q      <= 3'h7;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            strap_q <= {i_periph_data_bus[STRAP_B7],
                        i_periph_data_bus[STRAP_B6],
                        i_periph_data_bus[STRAP_B4]};
        end
    end

    always_comb begin
        case (strap_q)
            3'b100:  pmode = ISABG_PM_IOBUF;
            3'b010:  pmode = ISABG_PM_PWR;
            3'b110:  pmode = ISABG_PM_EXTCLK;
            default: pmode = ISABG_PM_EXTCLK;
        endcase
    end

    // ****************************************
    // Refresh, address enable, address buffers
    // ****************************************
    logic [ADDR_W-1:0] rfsh_addr_q;
    logic              in_rfsh;
    logic              master;

    assign in_rfsh = !rfsh_n_q;
    assign master  = !i_master_n;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rfsh_addr_q <= RFSH_RST;
        end else if (in_rfsh && rfsh_n_q == 1'b0 && s_rfsh_q[2]
                     && s_rfsh_q[1]) begin
            rfsh_addr_q <= rfsh_addr_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ref          <= 1'b0;
            o_aen          <= 1'b0;
            o_sa           <= '0;
            o_sa_oe        <= 1'b0;
            o_cpu_addr_bus <= '0;
            o_cpu_addr_oe  <= 1'b0;
        end else begin
            o_ref <= in_rfsh;
            // DMA owns the bus: hold ack with no refresh and no master
            o_aen <= i_hold_ack_in && !in_rfsh && !master;
            o_sa    <= in_rfsh ? rfsh_addr_q : i_cpu_addr_bus;
            o_sa_oe <= in_rfsh || !master;
            o_cpu_addr_bus <= i_sa;
            o_cpu_addr_oe  <= master && !in_rfsh;
        end
    end

    // ****************************************
    // Command strobes
    // ****************************************
    logic drive_cmd;
    assign drive_cmd = master && i_bidir_cmd;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_isa_cmd      <= '1;
            o_isa_cmd_oe   <= 4'h0;
            o_low_meg_rd_n <= 1'b1;
            o_low_meg_wr_n <= 1'b1;
        end else begin
            o_isa_cmd    <= i_cmd;
            o_isa_cmd_oe <= {drive_cmd, drive_cmd,
                             drive_cmd && !in_rfsh, drive_cmd};
            o_low_meg_rd_n <= in_rfsh ? i_cmd.memr_n : 1'b1;
            o_low_meg_wr_n <= 1'b1;
        end
    end

    // ****************************************
    // Data paths
    // ****************************************
    // Bytes toward the peripheral bus queue one cycle; full only raises o_fifo_full, SD is never stalled
    logic       f_rdy;
    logic       f_vld;
    logic [7:0] f_dat;
    logic       to_xd;
    assign to_xd = !i_periph_bus_dir_n;

    isabg_fifo #(.WIDTH(BYTE_W), .DEPTH(FDEPTH)) u_fifo (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_data   (i_sd),
        .i_valid  (to_xd),
        .o_ready  (f_rdy),
        .o_data   (f_dat),
        .o_valid  (f_vld),
        .i_ready  (to_xd)
    );

    logic [7:0] latch_q;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            latch_q <= 8'h00;
        end else if (!i_lane.sys_to_cpu_latch_n) begin
            latch_q <= i_sd;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_periph_data_bus <= 8'h00;
            o_periph_data_oe  <= 1'b0;
            o_sd              <= 8'h00;
            o_sd_oe           <= 1'b0;
            o_cpu_data_bus    <= 8'h00;
            o_cpu_data_oe     <= 1'b0;
            o_fifo_full       <= 1'b0;
        end else begin
            o_periph_data_bus <= f_dat;
            o_periph_data_oe  <= to_xd && f_vld && strap_done_q;
            o_fifo_full       <= !f_rdy;
            if (!i_lane.cpu_byte_to_sys_oe_n) begin
                o_sd    <= i_cpu_data_bus;
                o_sd_oe <= 1'b1;
            end else begin
                o_sd    <= i_periph_data_bus;
                o_sd_oe <= i_periph_bus_dir_n && strap_done_q;
            end
            o_cpu_data_bus <= latch_q;
            o_cpu_data_oe  <= !i_lane.sys_to_cpu_latch_oe_n;
        end
    end

    // ****************************************
    // Index registers, clock chip decode, pins 18/19/25
    // ****************************************
    logic [15:0] io_addr;
    logic        io_wr;
    logic [7:0]  index_q;
    logic [7:0]  cs_lo_q;
    logic [7:0]  cs_hi_q;
    logic [2:0]  pwr_q;
    logic        hit_idx;
    logic        hit_dat;
    logic        hit_cs;

    assign io_addr = {i_cpu_addr_bus, i_cpu_addr_low};
    assign io_wr   = !i_cmd.iow_n;
    assign hit_idx = io_addr == CLK_IDX_IO;
    assign hit_dat = io_addr == CLK_DAT_IO;
    assign hit_cs  = io_addr == {cs_hi_q, cs_lo_q};

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            index_q <= 8'h00;
            cs_lo_q <= CS_LO_RST;
            cs_hi_q <= CS_HI_RST;
            pwr_q   <= PWR_RST;
        end else begin
            if (io_wr && hit_idx) index_q <= i_sd;
            if (io_wr && hit_dat && index_q == IDX_CS_LO)
                cs_lo_q <= i_sd;
            if (io_wr && hit_dat && index_q == IDX_CS_HI)
                cs_hi_q <= i_sd;
            // Latch strobe edge wins, in power mode only; index path in every mode
            if (pmode == ISABG_PM_PWR && ppl_n_q && !ppl_prev_q)
                pwr_q <= i_periph_data_bus[2:0];
            else if (io_wr && hit_dat && index_q == IDX_PWR)
                pwr_q <= i_sd[2:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pin18_out             <= 1'b1;
            o_pin18_oe              <= 1'b0;
            o_pin19_out             <= 1'b1;
            o_pin19_oe              <= 1'b0;
            o_pin25_out             <= 1'b1;
            o_ext_clock_addr_strobe <= 1'b0;
            o_power_port_bit0_n     <= 1'b1;
        end else begin
            o_ext_clock_addr_strobe <= hit_idx && io_wr;
            o_power_port_bit0_n     <= pwr_q[0];
            case (pmode)
                ISABG_PM_IOBUF: begin
                    o_pin18_out <= i_cmd.ior_n;
                    o_pin19_out <= i_cmd.iow_n;
                    o_pin18_oe  <= 1'b1;
                    o_pin19_oe  <= 1'b1;
                    o_pin25_out <= 1'b1;
                end
                ISABG_PM_PWR: begin
                    o_pin18_out <= pwr_q[1];
                    o_pin19_out <= !(hit_cs &&
                                     !(i_cmd.ior_n && i_cmd.iow_n));
                    o_pin18_oe  <= 1'b1;
                    o_pin19_oe  <= 1'b1;
                    o_pin25_out <= pwr_q[2];
                end
                default: begin
                    o_pin18_out <= !(hit_dat && !(i_cmd.ior_n
                                                  && i_cmd.iow_n));
                    o_pin19_out <= i_cmd.iow_n;
                    o_pin18_oe  <= 1'b1;
                    o_pin19_oe  <= 1'b1;
                    // Only with the internal clock disabled is 25 a select
                    o_pin25_out <= strap_q[0] ? !(hit_idx || hit_dat)
                                              : 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Keyboard clock and resets
    // ****************************************
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_kbd_clock_out     <= 1'b0;
            o_kbd_clock_oe      <= 1'b0;
            o_isa_reset         <= 1'b1;
            o_local_bus_reset_n <= 1'b0;
        end else begin
            // Open-drain style: drive only the low level
            o_kbd_clock_out     <= 1'b0;
            o_kbd_clock_oe      <= !kbd_q;
            o_isa_reset         <= !system_reset_in_n_n_q;
            o_local_bus_reset_n <= system_reset_in_n_n_q;
        end
    end
endmodule // isabg_top

// >>> bench/isabg_chipset_model.sv
// Chipset stand-in issuing refresh cycles with a memory read strobe.
// Assumes the bench raises i_go for one cycle per refresh wanted.
`timescale 1ns/1ns
module isabg_chipset_model (
    input  wire logic i_clk,    // Bus clock
    input  wire logic i_go,     // Refresh request
    output logic      o_rfsh_n, // Refresh cycle
    output logic      o_memr_n  // Memory read
);
    initial begin
        o_rfsh_n = 1'b1;
        o_memr_n = 1'b1;
    end
    // ********
    // Refresh cycle
    // ********
    // Read held long enough to outlast the design's sync lag
    always begin
        @(posedge i_clk iff i_go);
        @(negedge i_clk);
        o_rfsh_n = 1'b0;
        repeat (2) @(negedge i_clk);
        o_memr_n = 1'b0;
        repeat (10) @(negedge i_clk);
        o_memr_n = 1'b1;
        @(negedge i_clk);
        o_rfsh_n = 1'b1;
    end
endmodule // isabg_chipset_model

// >>> bench/isabg_top_asserts.sv
// Port checks for the ISA glue top level.
// Assumes one clock and the power-good reset.
`timescale 1ns/1ns
module isabg_top_asserts
    import isabg_pkg::*;
(
    input wire logic        i_clk,               // Clock
    input wire logic        i_arst_n,            // Reset
    input wire logic        i_system_reset_in_n, // System reset
    input wire logic        i_master_n,          // Master cycle
    input wire logic        i_bidir_cmd,         // Two-way config
    input wire logic        i_hold_ack_in,       // Hold ack
    input wire isabg_lane_t i_lane,              // Lane controls
    input wire logic        i_periph_bus_dir_n,  // XD direction
    input wire logic [7:0]  i_periph_data_bus,   // XD in
    input wire logic [3:0]  o_isa_cmd_oe,        // Cmd enables
    input wire logic        o_ref,               // Refresh out
    input wire logic        o_sa_oe,             // ISA addr enable
    input wire logic        o_cpu_addr_oe,       // CPU addr enable
    input wire logic        o_aen,               // Address enable
    input wire logic [7:0]  o_sd,                // SD out
    input wire logic        o_sd_oe,             // SD enable
    input wire logic        o_isa_reset,         // ISA reset
    input wire logic        o_local_bus_reset_n  // Local reset
);
    // ********
    // Properties
    // ********
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_master;
        !i_master_n ##1 !o_ref;
    endsequence
    // Four low samples always get through the filter
    sequence s_sys_low;
        $fell(i_system_reset_in_n) ##1 !i_system_reset_in_n [*3];
    endsequence
    a_cmd_idle: assert property (
        (i_master_n || !i_bidir_cmd) |=> o_isa_cmd_oe == 4'h0)
        else $error("command pin driven outside master cycle");
    a_cmd_master: assert property (
        (!i_master_n && i_bidir_cmd) |=> o_isa_cmd_oe[3:2] == 2'h3)
        else $error("io command not driven in master cycle");
    a_memr_rfsh: assert property (o_ref |-> !o_isa_cmd_oe[1])
        else $error("memory read driven in refresh");
    a_master_dir: assert property (
        s_master |-> o_cpu_addr_oe && !o_sa_oe)
        else $error("address direction not reversed");
    a_ref_addr: assert property (o_ref |-> o_sa_oe && !o_cpu_addr_oe)
        else $error("refresh address not on ISA lines");
    a_aen_cause: assert property (
        o_aen |-> $past(i_hold_ack_in) && $past(i_master_n) && !o_ref)
        else $error("address enable without its cause");
    a_xd_to_sd: assert property (
        ($past(i_arst_n) && i_periph_bus_dir_n
         && i_lane.cpu_byte_to_sys_oe_n) |=>
        o_sd_oe && o_sd == $past(i_periph_data_bus))
        else $error("peripheral byte not passed to SD");
    a_rst_follow: assert property (s_sys_low |-> ##[1:3] o_isa_reset)
        else $error("ISA reset did not follow system reset");
    a_rst_pair: assert property (
        o_isa_reset == !o_local_bus_reset_n)
        else $error("bus resets disagree");
endmodule // isabg_top_asserts

// >>> bench/isabg_top_tb.sv
// Bench for the ISA glue top with a chipset stand-in.
// Assumes straps XD7=1 XD6=0 XD4=0: buffered IO command pins.
`timescale 1ns/1ns
module isabg_top_tb;
    import isabg_pkg::*;
    logic        i_clk;
    logic        i_arst_n = 1'b0;
    logic        sys_n = 1'b1;
    logic        mst_n = 1'b1;
    logic        hack = 1'b0;
    logic        dir_n = 1'b1;
    logic        go = 1'b0;
    logic        kbd = 1'b1;
    logic        bid = 1'b1;
    logic        cd_oe, pp0_n, kbd_o, kbd_oe;
    logic [1:0]  alo = 2'h0;
    logic        memr_n, rfsh_n, sa_oe, ca_oe, sd_oe, xd_oe, lmr_n, ref_o;
    logic        aen, p18, p19, p25, as_o, isa_rst, lrst_n;
    logic [13:0] ca = 14'h0000;
    logic [13:0] sa = 14'h0000;
    logic [13:0] sa_o, ca_o;
    logic [7:0]  xd = 8'haf;
    logic [7:0]  sd = 8'h00;
    logic [7:0]  cd = 8'h00;
    logic [7:0]  sd_o, xd_o, cd_o;
    logic [3:0]  c_oe;
    isabg_cmd_t  cmd = 4'hf;
    isabg_cmd_t  cmd_w;
    isabg_cmd_t  icmd;
    isabg_lane_t lane = 3'h7;
    int          num_errors = 0;
    int          comparisons = 0;
    assign cmd_w = {cmd.ior_n, cmd.iow_n, memr_n, cmd.memw_n};
    isabg_chipset_model u_isabg_chipset_model (.i_clk(i_clk), .i_go(go),
        .o_rfsh_n(rfsh_n), .o_memr_n(memr_n));
    isabg_top #(.FDEPTH(FIFO_DEPTH)) u_isabg_top (.i_clk(i_clk),
        .i_arst_n(i_arst_n), .i_system_reset_in_n(sys_n), .i_master_n(mst_n),
        .i_hold_ack_in(hack), .i_rfsh_n(rfsh_n), .i_bidir_cmd(bid),
        .i_cmd(cmd_w), .i_isa_cmd(4'hf), .o_isa_cmd(icmd),
        .o_isa_cmd_oe(c_oe), .o_low_meg_rd_n(lmr_n), .o_low_meg_wr_n(),
        .i_cpu_addr_bus(ca), .o_cpu_addr_bus(ca_o), .o_cpu_addr_oe(ca_oe),
        .i_sa(sa), .o_sa(sa_o), .o_sa_oe(sa_oe), .i_cpu_addr_low(alo),
        .i_periph_bus_dir_n(dir_n),
        .i_periph_data_bus(xd), .o_periph_data_bus(xd_o),
        .o_periph_data_oe(xd_oe), .i_sd(sd), .o_sd(sd_o), .o_sd_oe(sd_oe),
        .i_cpu_data_bus(cd), .o_cpu_data_bus(cd_o), .o_cpu_data_oe(cd_oe),
        .i_lane(lane), .o_ref(ref_o), .o_aen(aen), .o_pin18_out(p18),
        .o_pin18_oe(), .o_pin19_out(p19), .o_pin19_oe(), .o_pin25_out(p25),
        .o_ext_clock_addr_strobe(as_o), .o_power_port_bit0_n(pp0_n),
        .i_power_port_latch_n(1'b1), .i_kbd_ctrl_clock_in(kbd),
        .o_kbd_clock_out(kbd_o), .o_kbd_clock_oe(kbd_oe),
        .o_isa_reset(isa_rst),
        .o_local_bus_reset_n(lrst_n), .o_fifo_full());
    // ********
    // Tasks
    // ********
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wref(logic v);
        int k = 0;
        while (ref_o !== v && k < 30) begin
            cyc(1);
            k++;
        end
        chk("ref", v, ref_o);
    endtask
    task automatic t_bus;
        ca = 14'h2a5a;
        sa = 14'h1234;
        cyc(2);
        chk("sa", 16'haa5a, {sa_oe, 1'b0, sa_o});
        mst_n = 1'b0;
        cyc(2);
        chk("ca", 16'h9234, {ca_oe, 1'b0, ca_o});
        chk("cmd_oe", 16'h000f, c_oe);
        bid = 1'b0;
        cyc(2);
        chk("cmd_off", 16'h0000, c_oe);
        bid = 1'b1;
        mst_n = 1'b1;
        hack = 1'b1;
        cyc(2);
        chk("aen", 1, aen);
        hack = 1'b0;
        $display("bus test done");
    endtask
    task automatic t_data;
        xd = 8'h5a;
        cyc(2);
        chk("sd", 16'h015a, {sd_oe, sd_o});
        lane.cpu_byte_to_sys_oe_n = 1'b0;
        cd = 8'h96;
        cyc(2);
        chk("sd_cpu", 16'h0196, {sd_oe, sd_o});
        lane = 3'h6;
        dir_n = 1'b0;
        sd = 8'hc3;
        cyc(4);
        chk("xd", 16'h01c3, {xd_oe, xd_o});
        lane = 3'h5;
        sd = 8'h11;
        cyc(2);
        chk("cd", 16'h01c3, {cd_oe, cd_o});
        dir_n = 1'b1;
        lane = 3'h7;
        $display("data test done");
    endtask
    task automatic t_io;
        int n = 0;
        cmd.ior_n = 1'b0;
        cyc(2);
        chk("pin18", 0, p18);
        chk("isa_cmd", 16'h0007, icmd);
        cmd.ior_n = 1'b1;
        ca = 14'h001c;
        cmd.iow_n = 1'b0;
        repeat (8) begin
            cyc(1);
            n = n + int'(as_o === 1'b1);
        end
        chk("as_cnt", 8, n);
        chk("pin19", 0, p19);
        chk("pin25", 1, p25);
        cmd.iow_n = 1'b1;
        $display("io test done");
    endtask
    task automatic t_rfsh;
        for (int i = 0; i < 2; i++) begin
            mst_n = (i == 0);
            go = 1'b1;
            cyc(1);
            go = 1'b0;
            wref(1'b1);
            cyc(3);
            chk("rf_sa", {2'b10, RFSH_RST + 14'(i)}, {sa_oe, 1'b0, sa_o});
            chk("low_meg", 0, lmr_n);
            chk("memr_oe", 0, c_oe[1]);
            wref(1'b0);
        end
        mst_n = 1'b1;
        $display("refresh test done");
    endtask
    task automatic t_rst;
        sys_n = 1'b0;
        cyc(6);
        chk("rst", 16'h0010, {isa_rst, 3'b0, lrst_n});
        sys_n = 1'b1;
        kbd = 1'b0;
        cyc(8);
        chk("rst_off", 16'h0001, {isa_rst, 3'b0, lrst_n});
        chk("kbd", 16'h0001, {kbd_o, 3'b0, kbd_oe});
        kbd = 1'b1;
        $display("reset test done");
    endtask
    // Second power-good reset with the power-port straps
    task automatic t_pwr;
        xd = 8'h4f;
        i_arst_n = 1'b0;
        cyc(2);
        i_arst_n = 1'b1;
        cyc(2);
        ca = 14'h001c;
        alo = 2'h0;
        sd = 8'hfa;
        cmd.iow_n = 1'b0;
        cyc(1);
        alo = 2'h1;
        sd = 8'h04;
        cyc(1);
        cmd.iow_n = 1'b1;
        cyc(2);
        chk("pwr", 16'h0005, {p18, p25, pp0_n, p19});
        $display("power port test done");
    endtask
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // Whole run needs about 100 cycles
    initial begin
        repeat (3000) @(posedge i_clk);
        num_errors++;
        conclude;
    end
    initial begin
        cyc(8);
        i_arst_n = 1'b1;
        cyc(6);
        t_bus;
        t_data;
        t_io;
        t_rfsh;
        t_rst;
        t_pwr;
        conclude;
    end
endmodule // isabg_top_tb
bind isabg_top isabg_top_asserts u_isabg_top_asserts (.i_clk, .i_arst_n,
    .i_master_n, .i_bidir_cmd, .i_hold_ack_in, .i_lane, .i_periph_bus_dir_n,
    .i_periph_data_bus, .o_isa_cmd_oe, .o_ref, .o_sa_oe, .o_cpu_addr_oe,
    .o_aen, .o_sd, .o_sd_oe, .o_isa_reset, .o_local_bus_reset_n,
    .i_system_reset_in_n);
